/* File: rtl/dual_uart_host_bus_port.sv */
// Functional notes
// [R1] Read strobe fall fetches addressed byte onto bus.
// [R2] Write strobe rise loads bus byte into register.
// [R3] Chip select low needed; channel pick input picks channel.
// [R4] Channel pick low means B, high A.
// [R5] Broadcast bit makes writes reach both channels.
// [R6] Each channel drives active-high interrupt output.
// [R7] Active-low tx room follows FIFO or holding.
// [R8] Eight-bit bidirectional data bus, device drives reads.
// [R9] Three address bits select the register.
// [R10] Chip select high ignores strobes, bus released.
`timescale 1ns/1ps
`default_nettype none
`include "host_port_regs.svh"
module dual_uart_host_bus_port (
   // Clock and reset.
   input wire logic clock_in,
   input wire logic rst_in,
   // Host bus pins.
   input wire logic chip_sel_n_in,
   input wire logic read_strobe_n_in,
   input wire logic write_strobe_n_in,
   input wire logic channel_pick_in,
   input wire host_port_pkg::reg_addr_t addr_in,
   input wire host_port_pkg::byte_t data_in,
   output host_port_pkg::byte_t data_out,
   output logic data_oe_out,
   // Channel cores, same clock.
   input wire host_port_pkg::byte_t rd_data_a_in,
   input wire host_port_pkg::byte_t rd_data_b_in,
   input wire logic irq_req_a_in,
   input wire logic irq_req_b_in,
   input wire logic fifo_mode_a_in,
   input wire logic fifo_mode_b_in,
   input wire logic fifo_room_a_in,
   input wire logic fifo_room_b_in,
   input wire logic holding_empty_a_in,
   input wire logic holding_empty_b_in,
   output host_port_pkg::reg_addr_t reg_addr_out,
   output host_port_pkg::byte_t wr_data_out,
   output logic rd_pulse_a_out,
   output logic rd_pulse_b_out,
   output logic wr_pulse_a_out,
   output logic wr_pulse_b_out,
   output host_port_pkg::byte_t alternate_function_reg_out,
   // Channel status pins.
   output logic irq_chan_a_out,
   output logic irq_chan_b_out,
   output logic tx_room_a_n_out,
   output logic tx_room_b_n_out
);
   import host_port_pkg::*;

   logic [`HP_PIN_W-1:0] pins_async;
   logic [`HP_PIN_W-1:0] pins_sync;
   logic [`HP_PIN_W-1:0] pins_prev_r;
   logic [`HP_PIN_W-1:0] pins_prev_nxt;

   assign pins_async = {write_strobe_n_in, read_strobe_n_in, chip_sel_n_in, channel_pick_in, addr_in, data_in};

   pin_sync #(.WIDTH(`HP_PIN_W), .RST_VAL(`HP_PIN_IDLE)) u_pin_sync (
      .clock_in(clock_in),
      .rst_in(rst_in),
      .async_in(pins_async),
      .sync_out(pins_sync)
   );

   logic cs_n_s;
   logic rd_n_s;
   logic wr_n_s;
   logic pick_s;
   reg_addr_t addr_s;
   byte_t data_s;
   logic rd_fall;
   logic rd_rise;
   logic wr_fall;
   logic wr_rise;

   always_comb begin
      cs_n_s = pins_sync[`HP_PIN_CS_N];
      rd_n_s = pins_sync[`HP_PIN_RD_N];
      wr_n_s = pins_sync[`HP_PIN_WR_N];
      pick_s = pins_sync[`HP_PIN_PICK];
      addr_s = pins_sync[`HP_PIN_ADDR_LSB +: `HP_ADDR_W];
      data_s = pins_sync[`HP_PIN_DATA_LSB +: `HP_DATA_W];
      rd_fall = pins_prev_r[`HP_PIN_RD_N] & ~rd_n_s;
      rd_rise = ~pins_prev_r[`HP_PIN_RD_N] & rd_n_s;
      wr_fall = pins_prev_r[`HP_PIN_WR_N] & ~wr_n_s;
      wr_rise = ~pins_prev_r[`HP_PIN_WR_N] & wr_n_s;
      pins_prev_nxt = rst_in ? `HP_PIN_IDLE : pins_sync;
   end

   port_state_t state_r;
   port_state_t state_nxt;
   logic chan_a_r;
   logic chan_a_nxt;
   reg_addr_t addr_r;
   reg_addr_t addr_nxt;
   byte_t wdata_r;
   byte_t wdata_nxt;
   byte_t dout_r;
   byte_t dout_nxt;
   logic oe_r;
   logic oe_nxt;
   logic rd_a_r;
   logic rd_a_nxt;
   logic rd_b_r;
   logic rd_b_nxt;
   logic wr_a_r;
   logic wr_a_nxt;
   logic wr_b_r;
   logic wr_b_nxt;
   byte_t afr_r;
   byte_t afr_nxt;
   logic irq_a_r;
   logic irq_a_nxt;
   logic irq_b_r;
   logic irq_b_nxt;
   logic txr_a_r;
   logic txr_a_nxt;
   logic txr_b_r;
   logic txr_b_nxt;
   logic bcast;

   always_comb begin
      state_nxt = state_r;
      chan_a_nxt = chan_a_r;
      addr_nxt = addr_r;
      wdata_nxt = wdata_r;
      dout_nxt = dout_r;
      oe_nxt = oe_r;
      rd_a_nxt = 1'b0;
      rd_b_nxt = 1'b0;
      wr_a_nxt = 1'b0;
      wr_b_nxt = 1'b0;
      afr_nxt = afr_r;
      bcast = afr_r[`HP_ALT_BCAST_BIT];
      if (cs_n_s) begin
         state_nxt = ST_IDLE; // [R10]
         oe_nxt = 1'b0; // [R10]
      end else begin
         case (state_r)
            ST_IDLE: begin
               if (rd_fall) begin
                  state_nxt = ST_RD_FETCH; // [R1]
                  chan_a_nxt = pick_s; // [R3] [R4]
                  addr_nxt = addr_s; // [R9]
                  rd_a_nxt = pick_s && (addr_s != `HP_ALT_FUNC_ADDR);
                  rd_b_nxt = !pick_s && (addr_s != `HP_ALT_FUNC_ADDR);
               end else if (wr_fall) begin
                  state_nxt = ST_WR_HOLD; // [R2]
               end
            end
            ST_RD_FETCH: begin
               if (addr_r == `HP_ALT_FUNC_ADDR) begin
                  dout_nxt = afr_r;
               end else begin
                  dout_nxt = chan_a_r ? rd_data_a_in : rd_data_b_in; // [R1] [R4]
               end
               oe_nxt = 1'b1; // [R8]
               state_nxt = rd_n_s ? ST_IDLE : ST_RD_HOLD;
               if (rd_n_s) begin
                  oe_nxt = 1'b0;
               end
            end
            ST_RD_HOLD: begin
               if (rd_rise) begin
                  oe_nxt = 1'b0; // [R1] [R8]
                  state_nxt = ST_IDLE;
               end
            end
            ST_WR_HOLD: begin
               if (wr_rise) begin
                  state_nxt = ST_IDLE;
                  addr_nxt = addr_s; // [R9]
                  wdata_nxt = data_s; // [R2] [R8]
                  if (addr_s == `HP_ALT_FUNC_ADDR) begin
                     afr_nxt = data_s;
                  end else begin
                     wr_a_nxt = bcast || pick_s; // [R4] [R5]
                     wr_b_nxt = bcast || !pick_s; // [R4] [R5]
                  end
               end
            end
            default: begin
               state_nxt = ST_IDLE;
               oe_nxt = 1'b0;
            end
         endcase
      end
      irq_a_nxt = irq_req_a_in; // [R6]
      irq_b_nxt = irq_req_b_in; // [R6]
      txr_a_nxt = fifo_mode_a_in ? !fifo_room_a_in : !holding_empty_a_in; // [R7]
      txr_b_nxt = fifo_mode_b_in ? !fifo_room_b_in : !holding_empty_b_in; // [R7]
      if (rst_in) begin
         state_nxt = ST_IDLE;
         chan_a_nxt = 1'b0;
         addr_nxt = 3'h0;
         wdata_nxt = 8'h00;
         dout_nxt = 8'h00;
         oe_nxt = 1'b0;
         rd_a_nxt = 1'b0;
         rd_b_nxt = 1'b0;
         wr_a_nxt = 1'b0;
         wr_b_nxt = 1'b0;
         afr_nxt = `HP_ALT_FUNC_RST;
         irq_a_nxt = 1'b0;
         irq_b_nxt = 1'b0;
         txr_a_nxt = 1'b1;
         txr_b_nxt = 1'b1;
      end
   end

   always_ff @(posedge clock_in) begin
      pins_prev_r <= pins_prev_nxt;
      state_r <= state_nxt;
      chan_a_r <= chan_a_nxt;
      addr_r <= addr_nxt;
      wdata_r <= wdata_nxt;
      dout_r <= dout_nxt;
      oe_r <= oe_nxt;
      rd_a_r <= rd_a_nxt;
      rd_b_r <= rd_b_nxt;
      wr_a_r <= wr_a_nxt;
      wr_b_r <= wr_b_nxt;
      afr_r <= afr_nxt;
      irq_a_r <= irq_a_nxt;
      irq_b_r <= irq_b_nxt;
      txr_a_r <= txr_a_nxt;
      txr_b_r <= txr_b_nxt;
   end

   assign data_out = dout_r;
   assign data_oe_out = oe_r;
   assign reg_addr_out = addr_r;
   assign wr_data_out = wdata_r;
   assign rd_pulse_a_out = rd_a_r;
   assign rd_pulse_b_out = rd_b_r;
   assign wr_pulse_a_out = wr_a_r;
   assign wr_pulse_b_out = wr_b_r;
   assign alternate_function_reg_out = afr_r;
   assign irq_chan_a_out = irq_a_r;
   assign irq_chan_b_out = irq_b_r;
   assign tx_room_a_n_out = txr_a_r;
   assign tx_room_b_n_out = txr_b_r;

   default clocking cb @(posedge clock_in); endclocking
   default disable iff (rst_in);

   read_fetch_drive_a: assert property ((state_r == ST_IDLE) && !cs_n_s && rd_fall |-> ##2 oe_r) // [R1]
      else $error("read did not drive the bus two cycles after the strobe fall");
   read_release_a: assert property ((state_r == ST_RD_HOLD) && rd_rise |=> !oe_r) // [R1]
      else $error("bus still driven after read strobe rise");
   write_load_a: assert property ((state_r == ST_WR_HOLD) && !cs_n_s && wr_rise && (addr_s != `HP_ALT_FUNC_ADDR)
      |=> (wr_a_r || wr_b_r) && (wdata_r == $past(data_s))) // [R2]
      else $error("write rise did not load the data byte");
   pick_route_a: assert property (wr_a_r && !$past(afr_r[`HP_ALT_BCAST_BIT]) |-> $past(pick_s)) // [R4]
      else $error("channel A written while pick was low");
   bcast_both_a: assert property ((wr_a_r || wr_b_r) && $past(afr_r[`HP_ALT_BCAST_BIT]) |-> wr_a_r && wr_b_r) // [R5]
      else $error("broadcast write missed a channel");
   irq_follow_a: assert property (irq_req_a_in |=> irq_chan_a_out) // [R6]
      else $error("channel A interrupt not raised");
   tx_room_a: assert property (fifo_mode_b_in && fifo_room_b_in |=> !tx_room_b_n_out) // [R7]
      else $error("channel B tx room not shown");
   cs_release_a: assert property (cs_n_s |=> !oe_r && !wr_a_r && !wr_b_r && !rd_a_r && !rd_b_r) // [R10] [R3]
      else $error("activity while chip select high");

   read_seen_c: cover property (rd_a_r ##[1:8] oe_r);
   write_b_c: cover property (wr_b_r && !wr_a_r);
   bcast_c: cover property (wr_a_r && wr_b_r);
endmodule : dual_uart_host_bus_port
`default_nettype wire

/* File: rtl/host_port_regs.svh */
`ifndef HOST_PORT_REGS_SVH
`define HOST_PORT_REGS_SVH

// Width of the host data bus and of the register address.
`define HP_DATA_W 8
`define HP_ADDR_W 3
// Address at which the shared alternate-function register sits.
`define HP_ALT_FUNC_ADDR 3'h7
// Reset value of the alternate-function register.
`define HP_ALT_FUNC_RST 8'h00
// Bit of the alternate-function register that broadcasts writes.
`define HP_ALT_BCAST_BIT 0
// Width of the synchronised pin bundle and the field positions in it.
`define HP_PIN_W 15
`define HP_PIN_DATA_LSB 0
`define HP_PIN_ADDR_LSB 8
`define HP_PIN_PICK 11
`define HP_PIN_CS_N 12
`define HP_PIN_RD_N 13
`define HP_PIN_WR_N 14
// Bundle value while the host is idle: strobes and select high.
`define HP_PIN_IDLE 15'h7000

`endif

/* File: rtl/host_port_pkg.sv */
`default_nettype none
package host_port_pkg;
   typedef logic [7:0] byte_t;
   typedef logic [2:0] reg_addr_t;
   typedef enum logic [1:0] {
      ST_IDLE,
      ST_RD_FETCH,
      ST_RD_HOLD,
      ST_WR_HOLD
   } port_state_t;
endpackage : host_port_pkg
`default_nettype wire

/* File: rtl/pin_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
   parameter int WIDTH = 1,
   parameter logic [WIDTH-1:0] RST_VAL = '0
) (
   // Clock and reset.
   input wire logic clock_in,
   input wire logic rst_in,
   // Asynchronous input and its synchronised copy.
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] meta_r;
   logic [WIDTH-1:0] meta_nxt;
   logic [WIDTH-1:0] sync_r;
   logic [WIDTH-1:0] sync_nxt;

   always_comb begin
      meta_nxt = rst_in ? RST_VAL : async_in;
      sync_nxt = rst_in ? RST_VAL : meta_r;
   end

   always_ff @(posedge clock_in) begin
      meta_r <= meta_nxt;
      sync_r <= sync_nxt;
   end

   assign sync_out = sync_r;
endmodule : pin_sync
`default_nettype wire

/* File: verif/host_cpu_model.sv */
`timescale 1ns/1ps
`default_nettype none
module host_cpu_model
   import host_port_pkg::*;
(
   // Clock.
   input wire logic clock_in,
   // Device side of the data bus.
   input wire byte_t dev_data_in,
   input wire logic dev_oe_in,
   // Host pins and the resolved bus level.
   output logic cs_n_out,
   output logic rd_n_out,
   output logic wr_n_out,
   output logic pick_out,
   output reg_addr_t addr_out,
   output byte_t bus_out
);
   byte_t drv_r = 8'h00;
   logic drv_en_r = 1'b0;
   byte_t idle_r = 8'h5a;

   initial begin
      cs_n_out = 1'b1;
      rd_n_out = 1'b1;
      wr_n_out = 1'b1;
      pick_out = 1'b0;
      addr_out = 3'h0;
   end

   // A released bus shows a pattern that changes every cycle.
   always @(posedge clock_in) begin
      idle_r <= ~idle_r + 8'h01;
   end
   assign bus_out = dev_oe_in ? dev_data_in : (drv_en_r ? drv_r : idle_r);

   // One transfer: strobe low for 6 clocks, pins held 4 clocks past the rise.
   task automatic xfer(input logic wr, input logic cs_n, input logic p, input reg_addr_t a, input byte_t d,
                       output byte_t q);
      @(posedge clock_in);
      cs_n_out <= cs_n;
      pick_out <= p;
      addr_out <= a;
      drv_r <= d;
      drv_en_r <= wr;
      rd_n_out <= wr;
      wr_n_out <= !wr;
      repeat (6) @(posedge clock_in);
      q = bus_out;
      rd_n_out <= 1'b1;
      wr_n_out <= 1'b1;
      repeat (4) @(posedge clock_in);
      cs_n_out <= 1'b1;
      drv_en_r <= 1'b0;
      repeat (3) @(posedge clock_in);
   endtask : xfer
endmodule : host_cpu_model
`default_nettype wire

/* File: verif/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
   import host_port_pkg::*;
   logic clock_in = 1'b0;
   logic rst_in = 1'b1;
   wire logic cs_n, rd_n, wr_n, pick;
   wire reg_addr_t addr;
   reg_addr_t radr;
   wire byte_t bus;
   byte_t dout, wdat, alternate_function_reg, q, afr_m;
   byte_t rda = 8'h00;
   byte_t rdb = 8'h00;
   logic [7:0] st = 8'h00;
   logic [3:0] st_q = 4'h0;
   logic oe, ia, ib, ta, tbn, rpa, rpb, wpa, wpb;
   logic on = 1'b0;
   int cnt[4] = '{0, 0, 0, 0};
   int n_mismatch = 0;
   int total_checks = 0;

   always #20 clock_in = ~clock_in;

   host_cpu_model host_cpu_model_i (.clock_in(clock_in), .dev_data_in(dout), .dev_oe_in(oe), .cs_n_out(cs_n),
      .rd_n_out(rd_n), .wr_n_out(wr_n), .pick_out(pick), .addr_out(addr), .bus_out(bus));

   dual_uart_host_bus_port dual_uart_host_bus_port_i (.clock_in(clock_in), .rst_in(rst_in),
      .chip_sel_n_in(cs_n), .read_strobe_n_in(rd_n), .write_strobe_n_in(wr_n), .channel_pick_in(pick),
      .addr_in(addr), .data_in(bus), .data_out(dout), .data_oe_out(oe), .rd_data_a_in(rda), .rd_data_b_in(rdb),
      .irq_req_a_in(st[7]), .irq_req_b_in(st[6]), .fifo_mode_a_in(st[5]), .fifo_mode_b_in(st[4]),
      .fifo_room_a_in(st[3]), .fifo_room_b_in(st[2]), .holding_empty_a_in(st[1]), .holding_empty_b_in(st[0]),
      .reg_addr_out(radr), .wr_data_out(wdat), .rd_pulse_a_out(rpa), .rd_pulse_b_out(rpb),
      .wr_pulse_a_out(wpa), .wr_pulse_b_out(wpb), .alternate_function_reg_out(alternate_function_reg), .irq_chan_a_out(ia),
      .irq_chan_b_out(ib), .tx_room_a_n_out(ta), .tx_room_b_n_out(tbn));

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("Error at %0t: saw %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic summarize();
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : summarize

   // Status pins expected from the channel requests.
   function automatic logic [3:0] status_exp(input logic [7:0] s);
      return {s[7], s[6], s[5] ? !s[3] : !s[1], s[4] ? !s[2] : !s[0]};
   endfunction : status_exp

   // Pulses expected from one transfer, ordered read A, read B, write A, write B.
   function automatic logic [3:0] pulse_exp(input logic wr, input logic cs_n, input logic p, input reg_addr_t a,
                                            input logic bc);
      if (cs_n || a == 3'h7) begin
         return 4'h0;
      end
      if (wr) begin
         return {2'b00, p || bc, !p || bc};
      end
      return {p, !p, 2'b00};
   endfunction : pulse_exp

   // Status pins follow the channel requests one cycle later; pulses are counted.
   always @(posedge clock_in) begin
      if (on) begin
         chk({ia, ib, ta, tbn}, st_q);
      end
      st_q <= status_exp(st);
      st <= rst_in ? 8'h00 : 8'($urandom);
      cnt[0] <= cnt[0] + int'(rpa);
      cnt[1] <= cnt[1] + int'(rpb);
      cnt[2] <= cnt[2] + int'(wpa);
      cnt[3] <= cnt[3] + int'(wpb);
   end

   task automatic op(input logic wr, input logic cs_n, input logic p, input reg_addr_t a, input byte_t d);
      int c0[4];
      logic [3:0] e;
      c0 = cnt;
      e = pulse_exp(wr, cs_n, p, a, afr_m[0]);
      rda <= 8'($urandom);
      rdb <= 8'($urandom);
      host_cpu_model_i.xfer(wr, cs_n, p, a, d, q);
      if (!cs_n && a == 3'h7) begin
         if (wr) begin
            afr_m = d;
         end else begin
            chk(q, afr_m);
         end
         chk(alternate_function_reg, afr_m);
      end else if (!cs_n && wr) begin
         chk(wdat, d);
         chk(radr, a);
      end else if (!cs_n) begin
         chk(q, p ? rda : rdb);
         chk(radr, a);
      end
      for (int k = 0; k < 4; k++) begin
         chk(8'(cnt[k] - c0[k]), 8'(e[3 - k]));
      end
      chk(oe, 1'b0);
   endtask : op

   initial begin
      void'($urandom(84));
      afr_m = 8'h00;
      repeat (4) @(posedge clock_in);
      rst_in <= 1'b0;
      @(posedge clock_in);
      chk({oe, ia, ib, ta, tbn}, 8'h03);
      chk(alternate_function_reg, 8'h00);
      repeat (3) @(posedge clock_in);
      on <= 1'b1;
      // Broadcast on, write both channels, read the shared register, broadcast off.
      op(1'b1, 1'b0, 1'b0, 3'h7, 8'h01);
      op(1'b1, 1'b0, 1'b0, 3'h0, 8'ha5);
      op(1'b0, 1'b0, 1'b1, 3'h7, 8'h00);
      op(1'b1, 1'b0, 1'b1, 3'h6, 8'h3c);
      op(1'b1, 1'b0, 1'b0, 3'h7, 8'hfe);
      op(1'b1, 1'b1, 1'b1, 3'h2, 8'h77);
      op(1'b0, 1'b1, 1'b0, 3'h2, 8'h00);
      for (int i = 0; i < 80; i++) begin
         op(1'($urandom), ($urandom % 8) == 0, 1'($urandom), 3'($urandom), 8'($urandom));
      end
      summarize();
   end

   initial begin
      #200000;
      n_mismatch++;
      summarize();
   end
endmodule : tb
`default_nettype wire
